// ---- rtl/mpc_defines.vh ----
`ifndef MPC_DEFINES_VH
`define MPC_DEFINES_VH

// Register indices; byte address is four times the index
`define MPC_IDX_OSR_LO 6'h20
`define MPC_IDX_CR_HI 6'h21
`define MPC_IDX_CR_MID 6'h22
`define MPC_IDX_CR_LO 6'h23
`define MPC_IDX_GAIN_HI 6'h24
`define MPC_IDX_GAIN_LO 6'h25
`define MPC_IDX_RSSI 6'h26
`define MPC_IDX_RSSI_TH 6'h27
`define MPC_IDX_ANT1 6'h28
`define MPC_IDX_ANT2 6'h29
`define MPC_IDX_DAC 6'h30
`define MPC_IDX_IRQ_STAT 6'h3C
`define MPC_IDX_IRQ_MASK 6'h3D

// Reset values
`define MPC_RST_OSR_LO 8'h64
`define MPC_RST_CR_HI 8'h00
`define MPC_RST_CR_MID 8'h47
`define MPC_RST_CR_LO 8'hAE
`define MPC_RST_GAIN_HI 3'h0
`define MPC_RST_GAIN_LO 8'h8F
`define MPC_RST_RSSI 8'h00
`define MPC_RST_RSSI_TH 8'h00
`define MPC_RST_ANT 8'h00
`define MPC_RST_DAC 8'h8D
`define MPC_RST_IRQ 2'h0

// Field positions in the offset-high register
`define MPC_CR_OSR_HI 7:5
`define MPC_CR_STALL 4
`define MPC_CR_NCO_HI 3:0

// Field positions in the data access control register
`define MPC_DAC_RX_EN 7
`define MPC_DAC_LSB_FIRST 6
`define MPC_DAC_CRC_DONLY 5
`define MPC_DAC_TX_EN 3
`define MPC_DAC_CRC_EN 2
`define MPC_DAC_CRC_POLY 1:0

// Data mode code that selects FIFO mode
`define MPC_MODE_FIFO 2'h2

// Interrupt status bit positions
`define MPC_IRQ_RSSI 0
`define MPC_IRQ_ANT 1
`define MPC_IRQ_BITS 2

`endif

// ---- rtl/mpc_regs.v ----
`include "mpc_defines.vh"
`default_nettype none

module mpc_regs #(
    parameter AW = 8
) (
    input wire clk_i,
    input wire rst_i,
    // Wishbone classic slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [AW-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire ack_o,
    // Modem side inputs
    input wire [1:0] data_mode_i,
    input wire rx_active_i,
    input wire rssi_valid_i,
    input wire [7:0] rssi_i,
    input wire ant1_valid_i,
    input wire [7:0] ant1_rssi_i,
    input wire ant2_valid_i,
    input wire [7:0] ant2_rssi_i,
    // Configuration to the modem
    output wire [7:0] osr_int_o,
    output wire [2:0] osr_frac_o,
    output wire stall_ctrl_o,
    output wire [19:0] nco_offset_o,
    output wire [10:0] loop_gain_o,
    output wire rx_pkt_handling_o,
    output wire rx_raw_fill_o,
    output wire tx_pkt_handling_o,
    output wire tx_raw_send_o,
    output wire lsb_first_o,
    output wire crc_data_only_o,
    output wire crc_enable_o,
    output wire [1:0] crc_poly_o,
    output wire rssi_above_o,
    output wire irq_o
);

    // Register storage
    reg [7:0] osr_lo_ff;
    reg [7:0] cr_hi_ff;
    reg [7:0] cr_mid_ff;
    reg [7:0] cr_lo_ff;
    reg [2:0] gain_hi_ff;
    reg [7:0] gain_lo_ff;
    reg [7:0] rssi_ff;
    reg [7:0] rssi_th_ff;
    reg [7:0] ant1_ff;
    reg [7:0] ant2_ff;
    reg [7:0] dac_ff;
    reg [`MPC_IRQ_BITS-1:0] irq_stat_ff;
    reg [`MPC_IRQ_BITS-1:0] irq_mask_ff;

    // Bus handshake and derived outputs
    reg ack_ff;
    reg [7:0] rd_ff;
    reg [7:0] nxt_rd;
    reg rx_pkt_ff;
    reg rx_raw_ff;
    reg tx_pkt_ff;
    reg tx_raw_ff;
    reg above_ff;
    reg irq_ff;

    wire [5:0] idx;
    wire req;
    wire wr_ack;
    wire wr_lane;
    wire [7:0] wd;
    wire fifo_mode;
    wire above_now;
    wire [`MPC_IRQ_BITS-1:0] irq_evt;
    wire [`MPC_IRQ_BITS-1:0] irq_clr;
    wire [`MPC_IRQ_BITS-1:0] nxt_irq_stat;

    // Address decode: word index from the byte address
    assign idx = adr_i[7:2];
    assign req = cyc_i & stb_i;
    assign wd = dat_i[7:0];
    assign wr_lane = sel_i[0];

    // Write takes effect at the edge where ack is seen high
    assign wr_ack = req & we_i & ack_ff & wr_lane;

    // Ack one cycle after the request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Read mux; unmapped indices read zero
    always @* begin
        nxt_rd = 8'h00;
        case (idx)
            `MPC_IDX_OSR_LO: begin
                nxt_rd = osr_lo_ff;
            end
            `MPC_IDX_CR_HI: begin
                nxt_rd = cr_hi_ff;
            end
            `MPC_IDX_CR_MID: begin
                nxt_rd = cr_mid_ff;
            end
            `MPC_IDX_CR_LO: begin
                nxt_rd = cr_lo_ff;
            end
            `MPC_IDX_GAIN_HI: begin
                nxt_rd = {5'h00, gain_hi_ff};
            end
            `MPC_IDX_GAIN_LO: begin
                nxt_rd = gain_lo_ff;
            end
            `MPC_IDX_RSSI: begin
                nxt_rd = rssi_ff;
            end
            `MPC_IDX_RSSI_TH: begin
                nxt_rd = rssi_th_ff;
            end
            `MPC_IDX_ANT1: begin
                nxt_rd = ant1_ff;
            end
            `MPC_IDX_ANT2: begin
                nxt_rd = ant2_ff;
            end
            `MPC_IDX_DAC: begin
                nxt_rd = dac_ff;
            end
            `MPC_IDX_IRQ_STAT: begin
                nxt_rd = {6'h00, irq_stat_ff};
            end
            `MPC_IDX_IRQ_MASK: begin
                nxt_rd = {6'h00, irq_mask_ff};
            end
            default: begin
                nxt_rd = 8'h00;
            end
        endcase
    end

    // Read data is captured together with ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_ff <= 8'h00;
        end else if (req & ~ack_ff) begin
            rd_ff <= nxt_rd;
        end
    end

    // Clock recovery rate and offset registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            osr_lo_ff <= `MPC_RST_OSR_LO;
            cr_hi_ff <= `MPC_RST_CR_HI;
            cr_mid_ff <= `MPC_RST_CR_MID;
            cr_lo_ff <= `MPC_RST_CR_LO;
        end else if (wr_ack) begin
            if (idx == `MPC_IDX_OSR_LO) begin
                osr_lo_ff <= wd;
            end
            if (idx == `MPC_IDX_CR_HI) begin
                cr_hi_ff <= wd;
            end
            if (idx == `MPC_IDX_CR_MID) begin
                cr_mid_ff <= wd;
            end
            if (idx == `MPC_IDX_CR_LO) begin
                cr_lo_ff <= wd;
            end
        end
    end

    // Timing loop gain; reserved upper bits are not stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            gain_hi_ff <= `MPC_RST_GAIN_HI;
            gain_lo_ff <= `MPC_RST_GAIN_LO;
        end else if (wr_ack) begin
            if (idx == `MPC_IDX_GAIN_HI) begin
                gain_hi_ff <= wd[2:0];
            end
            if (idx == `MPC_IDX_GAIN_LO) begin
                gain_lo_ff <= wd;
            end
        end
    end

    // Threshold and data access control
    always @(posedge clk_i) begin
        if (rst_i) begin
            rssi_th_ff <= `MPC_RST_RSSI_TH;
            dac_ff <= `MPC_RST_DAC;
        end else if (wr_ack) begin
            if (idx == `MPC_IDX_RSSI_TH) begin
                rssi_th_ff <= wd;
            end
            if (idx == `MPC_IDX_DAC) begin
                dac_ff <= wd;
            end
        end
    end

    // Measured strength, refreshed on every sample while receiving
    always @(posedge clk_i) begin
        if (rst_i) begin
            rssi_ff <= `MPC_RST_RSSI;
        end else if (rssi_valid_i & rx_active_i) begin
            rssi_ff <= rssi_i;
        end
    end

    // Per-antenna readings for diversity
    always @(posedge clk_i) begin
        if (rst_i) begin
            ant1_ff <= `MPC_RST_ANT;
            ant2_ff <= `MPC_RST_ANT;
        end else begin
            if (ant1_valid_i) begin
                ant1_ff <= ant1_rssi_i;
            end
            if (ant2_valid_i) begin
                ant2_ff <= ant2_rssi_i;
            end
        end
    end

    // Packet handling enables depend on FIFO mode
    assign fifo_mode = (data_mode_i == `MPC_MODE_FIFO);

    // Registered packet path selection
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_pkt_ff <= 1'b0;
            rx_raw_ff <= 1'b0;
            tx_pkt_ff <= 1'b0;
            tx_raw_ff <= 1'b0;
        end else begin
            rx_pkt_ff <= fifo_mode & dac_ff[`MPC_DAC_RX_EN];
            rx_raw_ff <= ~(fifo_mode & dac_ff[`MPC_DAC_RX_EN]);
            tx_pkt_ff <= fifo_mode & dac_ff[`MPC_DAC_TX_EN];
            tx_raw_ff <= ~(fifo_mode & dac_ff[`MPC_DAC_TX_EN]);
        end
    end

    // Strength compared against threshold, strictly above
    assign above_now = (rssi_ff > rssi_th_ff);

    // Interrupt events: over threshold, and a new antenna reading
    assign irq_evt[`MPC_IRQ_RSSI] = above_now;
    assign irq_evt[`MPC_IRQ_ANT] = ant1_valid_i | ant2_valid_i;

    // Status bits: write one clears, an event in the same cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < `MPC_IRQ_BITS; gi = gi + 1) begin : g_irq
            assign irq_clr[gi] = wr_ack & (idx == `MPC_IDX_IRQ_STAT) & wd[gi];
            assign nxt_irq_stat[gi] = irq_evt[gi] | (irq_stat_ff[gi] & ~irq_clr[gi]);
        end
    endgenerate

    // Sticky status and mask registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= `MPC_RST_IRQ;
            irq_mask_ff <= `MPC_RST_IRQ;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_ack & (idx == `MPC_IDX_IRQ_MASK)) begin
                irq_mask_ff <= wd[`MPC_IRQ_BITS-1:0];
            end
        end
    end

    // Level interrupt and comparator flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
            above_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
            above_ff <= above_now;
        end
    end

    // Bus outputs
    assign ack_o = ack_ff;
    assign dat_o = {24'h000000, rd_ff};

    // Oversampling rate: integer part and three fraction bits
    assign osr_int_o = {cr_hi_ff[`MPC_CR_OSR_HI], osr_lo_ff[7:3]};
    assign osr_frac_o = osr_lo_ff[2:0];
    assign stall_ctrl_o = cr_hi_ff[`MPC_CR_STALL];

    // NCO offset and loop gain as written by the host
    assign nco_offset_o = {cr_hi_ff[`MPC_CR_NCO_HI], cr_mid_ff, cr_lo_ff};
    assign loop_gain_o = {gain_hi_ff, gain_lo_ff};

    // Packet path and CRC controls
    assign rx_pkt_handling_o = rx_pkt_ff;
    assign rx_raw_fill_o = rx_raw_ff;
    assign tx_pkt_handling_o = tx_pkt_ff;
    assign tx_raw_send_o = tx_raw_ff;
    assign lsb_first_o = dac_ff[`MPC_DAC_LSB_FIRST];
    assign crc_data_only_o = dac_ff[`MPC_DAC_CRC_DONLY];
    assign crc_enable_o = dac_ff[`MPC_DAC_CRC_EN];
    assign crc_poly_o = dac_ff[`MPC_DAC_CRC_POLY];

    // Flags
    assign rssi_above_o = above_ff;
    assign irq_o = irq_ff;

endmodule

`default_nettype wire

// ---- verification/mpc_regs_asserts.sv ----
`default_nettype none
module mpc_regs_asserts #(
    parameter AW = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [AW-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic [1:0] data_mode_i,
    input wire logic rx_active_i,
    input wire logic rssi_valid_i,
    input wire logic [7:0] rssi_i,
    input wire logic [7:0] osr_int_o,
    input wire logic [19:0] nco_offset_o,
    input wire logic [10:0] loop_gain_o,
    input wire logic rx_pkt_handling_o,
    input wire logic rx_raw_fill_o,
    input wire logic tx_pkt_handling_o,
    input wire logic lsb_first_o,
    input wire logic crc_data_only_o,
    input wire logic crc_enable_o,
    input wire logic [1:0] crc_poly_o,
    input wire logic rssi_above_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Write that lands at this edge
    wire wr_c = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answer timing, and configuration held between writes
    ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    config_hold_a: assert property (!wr_c |=> $stable(nco_offset_o)
        && $stable(loop_gain_o) && $stable(crc_poly_o)) else $error("config drift");
    // Field placement after writes
    dac_fields_a: assert property (
        wr_c && adr_i == 8'hC0 |=> {lsb_first_o, crc_data_only_o, crc_enable_o, crc_poly_o}
        == {$past(dat_i[6:5]), $past(dat_i[2:0])}) else $error("control fields wrong");
    gain_field_a: assert property (
        wr_c && adr_i == 8'h90 |=> loop_gain_o[10:8] == $past(dat_i[2:0]))
        else $error("gain bits wrong");
    offset_high_a: assert property (
        wr_c && adr_i == 8'h84 |=> {osr_int_o[7:5], nco_offset_o[19:16]}
        == {$past(dat_i[7:5]), $past(dat_i[3:0])}) else $error("offset bits wrong");
    // Packet handling decode and strict threshold comparison
    raw_inverse_a: assert property (
        !$past(rst_i) && !$past(rst_i, 2)
        |-> rx_raw_fill_o != rx_pkt_handling_o) else $error("raw fill not inverse");
    fifo_mode_a: assert property (
        data_mode_i != 2'h2 && $past(data_mode_i) != 2'h2
        |-> !rx_pkt_handling_o && !tx_pkt_handling_o) else $error("packet outside fifo");
    above_strict_a: assert property (
        rssi_valid_i && rx_active_i && rssi_i == 8'h00 ##1 !rssi_valid_i
        |=> !rssi_above_o) else $error("zero above threshold");
    // Main scenarios
    cover property (irq_o);
    cover property (rssi_above_o);
    cover property (rx_pkt_handling_o && tx_pkt_handling_o);
endmodule
bind mpc_regs mpc_regs_asserts #(.AW(AW)) mpc_regs_asserts_i (.*);
`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, rx_active_i, rssi_valid_i, ack_o, irq_o;
    logic ant1_valid_i, ant2_valid_i, stall_ctrl_o, rx_pkt_handling_o, rx_raw_fill_o;
    logic tx_pkt_handling_o, tx_raw_send_o, lsb_first_o, crc_data_only_o, crc_enable_o;
    logic rssi_above_o;
    logic [7:0] adr_i, rssi_i, ant1_rssi_i, ant2_rssi_i, osr_int_o, q, d;
    logic [3:0] sel_i;
    logic [1:0] data_mode_i, crc_poly_o;
    logic [2:0] osr_frac_o;
    logic [19:0] nco_offset_o;
    logic [10:0] loop_gain_o;
    logic [31:0] dat_i, dat_o, seed;
    logic [7:0] mem [8];
    logic [7:0] rv [10] = '{8'h64, 8'h00, 8'h47, 8'hAE, 8'h00, 8'h8F, 8'h00, 8'h00, 8'h00, 8'h00};
    int errors, check_count;
    mpc_regs #(.AW(8)) mpc_regs_i (.*);
    // Clock
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // One classic bus cycle, read data left in q
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, v};
        do @(posedge clk_i); while (ack_o !== 1'h1);
        q = dat_o[7:0];
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(a, 1'h0, 8'h00);
        chk(32'(q), 32'(e));
    endtask
    task automatic pulse(input logic act, input logic [7:0] v);
        @(posedge clk_i);
        rx_active_i <= act;
        rssi_valid_i <= 1'h1;
        rssi_i <= v;
        @(posedge clk_i);
        rssi_valid_i <= 1'h0;
        repeat (4) @(posedge clk_i);
    endtask
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // Packet path expected from mode code and enable bit
    function automatic logic exp_pkt(input int m, input logic en);
        return (m % 4 == 2) && en;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        seed = 32'h9E36;
        {cyc_i, stb_i, we_i, rx_active_i, rssi_valid_i, ant1_valid_i, ant2_valid_i} = 7'h00;
        {adr_i, rssi_i, ant1_rssi_i, ant2_rssi_i, data_mode_i} = 34'h0;
        sel_i = 4'hF;
        dat_i = 32'h0;
        rst_i = 1'h1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 10; i++) rd(8'h80 + 8'(4 * i), rv[i]);
        rd(8'hC0, 8'h8D);
        rd(8'h00, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            wb(8'h80 + 8'(4 * i), 1'h1, d);
            mem[i] = d & (i == 4 ? 8'h07 : i == 6 ? 8'h00 : 8'hFF);
        end
        for (int i = 0; i < 8; i++) rd(8'h80 + 8'(4 * i), mem[i]);
        // A write without the low byte lane must leave the register alone
        sel_i <= 4'hE;
        wb(8'h9C, 1'h1, ~mem[7]);
        sel_i <= 4'hF;
        rd(8'h9C, mem[7]);
        chk(32'(osr_int_o), 32'({mem[1][7:5], mem[0][7:3]}));
        chk(32'(osr_frac_o), 32'(mem[0][2:0]));
        chk(32'(stall_ctrl_o), 32'(mem[1][4]));
        chk(32'(nco_offset_o), 32'({mem[1][3:0], mem[2], mem[3]}));
        chk(32'(loop_gain_o), 32'({mem[4][2:0], mem[5]}));
        $display("register access done");
        for (int m = 0; m < 8; m++) begin
            d = rnd();
            d[1:0] = 2'(m);
            // FIFO mode sees both enables on once and both off once
            d[7] = (m != 6);
            d[3] = (m != 6);
            wb(8'hC0, 1'h1, d);
            data_mode_i <= 2'(m);
            repeat (3) @(posedge clk_i);
            chk(32'(rx_pkt_handling_o), 32'(exp_pkt(m, d[7])));
            chk(32'(rx_raw_fill_o), 32'(!exp_pkt(m, d[7])));
            chk(32'(tx_pkt_handling_o), 32'(exp_pkt(m, d[3])));
            chk(32'(tx_raw_send_o), 32'(!exp_pkt(m, d[3])));
            chk(32'({lsb_first_o, crc_data_only_o, crc_enable_o, crc_poly_o}),
                32'({d[6:5], d[2:0]}));
        end
        $display("packet control done");
        wb(8'h9C, 1'h1, 8'h40);
        wb(8'hF4, 1'h1, 8'h01);
        pulse(1'h0, 8'h77);
        rd(8'h98, 8'h00);
        pulse(1'h1, 8'h00);
        pulse(1'h1, 8'h40);
        rd(8'h98, 8'h40);
        chk(32'({rssi_above_o, irq_o}), 32'h0);
        pulse(1'h1, 8'h41);
        chk(32'({rssi_above_o, irq_o}), 32'h3);
        wb(8'hF4, 1'h1, 8'h00);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        wb(8'hF4, 1'h1, 8'h01);
        pulse(1'h1, 8'h10);
        chk(32'(irq_o), 32'h1);
        wb(8'hF0, 1'h1, 8'h03);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        d = rnd();
        @(posedge clk_i);
        ant1_valid_i <= 1'h1;
        ant1_rssi_i <= d;
        @(posedge clk_i);
        ant1_valid_i <= 1'h0;
        ant2_valid_i <= 1'h1;
        ant2_rssi_i <= ~d;
        @(posedge clk_i);
        ant2_valid_i <= 1'h0;
        rd(8'hA0, d);
        rd(8'hA4, ~d);
        rd(8'hF0, 8'h02);
        chk(32'(irq_o), 32'h0);
        wb(8'hF4, 1'h1, 8'h02);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        // Clear while the strength stays above threshold: the event wins
        pulse(1'h1, 8'h50);
        wb(8'hF0, 1'h1, 8'h01);
        rd(8'hF0, 8'h03);
        $display("signal strength done");
        report_and_stop();
    end
endmodule
`default_nettype wire
